// File: hw/wsc_command_port.sv
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module wsc_command_port (
  input wire logic clock_i, // system clock, 50 MHz
  input wire logic reset_i, // async reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [3:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic [7:0] rx_data_i, // received character
  input wire logic rx_valid_i, // one-cycle strobe with rx_data_i
  output logic [7:0] tx_data_o, // character to send
  output logic tx_valid_o, // tx_data_o is valid
  input wire logic tx_ready_i, // uart takes tx_data_o
  output logic baud_tick_o, // one-cycle pulse per bit time
  input wire wsc_pkg::wsc_meas_t meas_i, // measurement text and range code
  output logic [2:0] alarm_o, // alarm set point code
  output logic [wsc_pkg::MODE_W-1:0] mode_o, // operating mode
  output wsc_pkg::wsc_pmode_t pmode_o // power display mode
);

  // ==========================================================
  // state
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [2:0] alarm;
    logic [wsc_pkg::MODE_W-1:0] mode;
    wsc_pkg::wsc_pmode_t pmode;
    logic [47:0] call;
    logic [wsc_pkg::REC_LEN*8-1:0] rec;
    logic [wsc_pkg::IDX_W-1:0] idx;
    logic busy;
    logic [7:0] drops;
    logic [wsc_pkg::DIV_W-1:0] div;
    logic tick;
  } wsc_state_t;

  wsc_state_t s_q;
  wsc_state_t s_d;

  // ==========================================================
  // helpers
  function automatic logic [7:0] wsc_digit(input logic [2:0] v);
    return wsc_pkg::CH_ZERO + {5'h0, v};
  endfunction

  function automatic logic [47:0] wsc_pad(input logic [47:0] c);
    logic [47:0] r;
    r = c;
    for (int i = 0; i < wsc_pkg::CALL_LEN; i++) begin
      if (c[i*8 +: 8] == 8'h00) begin
        r[i*8 +: 8] = wsc_pkg::CH_SPACE;
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] wsc_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // record image, fixed width so every field sits at a known byte
  logic [wsc_pkg::REC_LEN*8-1:0] record;
  logic peak_code;

  always_comb begin
    peak_code = (s_q.pmode == wsc_pkg::PM_PEAK);
    record = {wsc_pkg::CH_SEMI,
      meas_i.power, wsc_pkg::CH_COMMA,
      meas_i.z, wsc_pkg::CH_COMMA,
      meas_i.phase, wsc_pkg::CH_COMMA,
      wsc_digit(s_q.alarm), wsc_pkg::CH_COMMA,
      wsc_pad(s_q.call), wsc_pkg::CH_COMMA,
      wsc_digit({1'b0, meas_i.range}), wsc_pkg::CH_COMMA,
      wsc_digit({2'h0, peak_code}), wsc_pkg::CH_COMMA,
      meas_i.dbm, wsc_pkg::CH_COMMA,
      meas_i.swr};
  end

  // ==========================================================
  // next state
  logic bus_req;
  logic [31:0] settings_rd;
  logic [31:0] wval;

  always_comb begin
    s_d = s_q;
    bus_req = wb_cyc_i && wb_stb_i;
    settings_rd = 32'h0;
    settings_rd[wsc_pkg::SET_ALARM_LSB +: 3] = s_q.alarm;
    settings_rd[wsc_pkg::SET_MODE_LSB +: wsc_pkg::MODE_W] = s_q.mode;
    settings_rd[wsc_pkg::SET_PMODE_LSB +: 2] = s_q.pmode;
    wval = 32'h0;

    // bit-time divider for the uart engine
    s_d.tick = 1'b0;
    if (s_q.div == wsc_pkg::DIV_W'(wsc_pkg::BIT_CYCLES - 1)) begin
      s_d.div = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.div = s_q.div + 1'b1;
    end

    // record transmit: one byte per uart handshake
    if (s_q.busy && tx_ready_i) begin
      s_d.rec = {s_q.rec[wsc_pkg::REC_LEN*8-9:0], 8'h00};
      if (s_q.idx == wsc_pkg::REC_LAST) begin
        s_d.busy = 1'b0;
        s_d.idx = '0;
      end else begin
        s_d.idx = s_q.idx + 1'b1;
      end
    end

    // command decode
    if (rx_valid_i) begin
      unique case (rx_data_i)
        wsc_pkg::CMD_ALARM: begin
          if (s_q.alarm >= wsc_pkg::ALARM_LAST) begin
            s_d.alarm = wsc_pkg::ALARM_OFF;
          end else begin
            s_d.alarm = s_q.alarm + 1'b1;
          end
        end
        wsc_pkg::CMD_MODE: begin
          if (s_q.mode >= wsc_pkg::MODE_COUNT - 1'b1) begin
            s_d.mode = '0;
          end else begin
            s_d.mode = s_q.mode + 1'b1;
          end
        end
        wsc_pkg::CMD_PWR: begin
          unique case (s_q.pmode)
            wsc_pkg::PM_PEAK: s_d.pmode = wsc_pkg::PM_AVG;
            wsc_pkg::PM_AVG: s_d.pmode = wsc_pkg::PM_TUNE;
            default: s_d.pmode = wsc_pkg::PM_PEAK;
          endcase
        end
        wsc_pkg::CMD_POLL: begin
          // a poll during a record is dropped so records never interleave
          if (!s_q.busy) begin
            s_d.rec = record;
            s_d.busy = 1'b1;
            s_d.idx = '0;
          end else begin
            s_d.drops = s_q.drops + 1'b1;
          end
        end
        default: begin
          s_d.drops = s_q.drops + 1'b1;
        end
      endcase
    end

    // wishbone: ack one cycle after the request, write at the ack edge
    s_d.ack = bus_req && !s_q.ack;
    if (bus_req && !s_q.ack) begin
      unique case (wb_adr_i)
        wsc_pkg::REG_SETTINGS: s_d.rdat = settings_rd;
        wsc_pkg::REG_CALL_HI: s_d.rdat = {16'h0, s_q.call[47:32]};
        wsc_pkg::REG_CALL_LO: s_d.rdat = s_q.call[31:0];
        wsc_pkg::REG_STATUS: begin
          s_d.rdat = 32'h0;
          s_d.rdat[wsc_pkg::STA_BUSY_BIT] = s_q.busy;
          s_d.rdat[wsc_pkg::STA_DROP_LSB +: 8] = s_q.drops;
        end
        default: s_d.rdat = 32'h0;
      endcase
    end
    if (bus_req && s_q.ack && wb_we_i) begin
      unique case (wb_adr_i)
        wsc_pkg::REG_SETTINGS: begin
          wval = wsc_merge(settings_rd, wb_dat_i, wb_sel_i);
          if (wval[wsc_pkg::SET_ALARM_LSB +: 3] <= wsc_pkg::ALARM_LAST) begin
            s_d.alarm = wval[wsc_pkg::SET_ALARM_LSB +: 3];
          end
          if (wval[wsc_pkg::SET_MODE_LSB +: wsc_pkg::MODE_W] < wsc_pkg::MODE_COUNT) begin
            s_d.mode = wval[wsc_pkg::SET_MODE_LSB +: wsc_pkg::MODE_W];
          end
          if (wval[wsc_pkg::SET_PMODE_LSB +: 2] != 2'h3) begin
            s_d.pmode = wsc_pkg::wsc_pmode_t'(wval[wsc_pkg::SET_PMODE_LSB +: 2]);
          end
        end
        wsc_pkg::REG_CALL_HI: begin
          wval = wsc_merge({16'h0, s_q.call[47:32]}, wb_dat_i, wb_sel_i);
          s_d.call[47:32] = wval[15:0];
        end
        wsc_pkg::REG_CALL_LO: begin
          s_d.call[31:0] = wsc_merge(s_q.call[31:0], wb_dat_i, wb_sel_i);
        end
        wsc_pkg::REG_STATUS: begin
          s_d.drops = 8'h00;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      s_q <= '{ack: 1'b0, rdat: 32'h0, alarm: wsc_pkg::ALARM_OFF, mode: wsc_pkg::MODE_RESET,
               pmode: wsc_pkg::PMODE_RESET, call: wsc_pkg::CALL_RESET, rec: '0, idx: '0,
               busy: 1'b0, drops: 8'h00, div: '0, tick: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign tx_valid_o = s_q.busy;
  assign tx_data_o = s_q.rec[wsc_pkg::REC_LEN*8-1 -: 8];
  assign baud_tick_o = s_q.tick;
  assign alarm_o = s_q.alarm;
  assign mode_o = s_q.mode;
  assign pmode_o = s_q.pmode;

endmodule

// File: hw/wsc_pkg.sv
package wsc_pkg;

  // ==========================================================
  // serial line format
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned BAUD_RATE = 115_200;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned STOP_BITS = 1;
  localparam int unsigned PARITY_BITS = 0;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE;
  localparam int unsigned DIV_W = 9;

  // ==========================================================
  // command characters and record punctuation
  localparam logic [7:0] CMD_ALARM = 8'h41;
  localparam logic [7:0] CMD_MODE = 8'h4D;
  localparam logic [7:0] CMD_PWR = 8'h46;
  localparam logic [7:0] CMD_POLL = 8'h50;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_ZERO = 8'h30;

  // ==========================================================
  // settings
  localparam logic [2:0] ALARM_OFF = 3'h0;
  localparam logic [2:0] ALARM_LAST = 3'h4;
  localparam int unsigned MODE_W = 3;
  localparam logic [MODE_W-1:0] MODE_COUNT = 3'h4;
  localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;
  localparam int unsigned CALL_LEN = 6;

  typedef enum logic [1:0] {
    PM_PEAK,
    PM_AVG,
    PM_TUNE
  } wsc_pmode_t;

  localparam wsc_pmode_t PMODE_RESET = PM_AVG;

  // ==========================================================
  // measurement text, most significant byte sent first
  localparam int unsigned PWR_LEN = 7;
  localparam int unsigned Z_LEN = 4;
  localparam int unsigned PH_LEN = 5;
  localparam int unsigned DBM_LEN = 4;
  localparam int unsigned SWR_LEN = 4;

  typedef struct packed {
    logic [PWR_LEN*8-1:0] power;
    logic [Z_LEN*8-1:0] z;
    logic [PH_LEN*8-1:0] phase;
    logic [DBM_LEN*8-1:0] dbm;
    logic [SWR_LEN*8-1:0] swr;
    logic [1:0] range;
  } wsc_meas_t;

  localparam int unsigned REC_LEN = 1 + PWR_LEN + Z_LEN + PH_LEN + 1 + CALL_LEN + 1 + 1 + DBM_LEN + SWR_LEN + 8;
  localparam int unsigned IDX_W = 6;
  localparam logic [IDX_W-1:0] REC_LAST = IDX_W'(REC_LEN - 1);

  // ==========================================================
  // register map (byte addresses)
  localparam logic [3:0] REG_SETTINGS = 4'h0;
  localparam logic [3:0] REG_CALL_HI = 4'h4;
  localparam logic [3:0] REG_CALL_LO = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hC;
  localparam int unsigned SET_ALARM_LSB = 0;
  localparam int unsigned SET_MODE_LSB = 4;
  localparam int unsigned SET_PMODE_LSB = 8;
  localparam int unsigned STA_BUSY_BIT = 0;
  localparam int unsigned STA_DROP_LSB = 8;
  localparam logic [47:0] CALL_RESET = 48'h0;

endpackage

// File: bench/wsc_checker.sv
`timescale 1ns/1ps
module wsc_checker (
  input wire logic clock_i, // system clock
  input wire logic reset_i, // async reset
  input wire logic wb_cyc_i, // bus cycle
  input wire logic [7:0] rx_data_i, // received char
  input wire logic rx_valid_i, // char strobe
  input wire logic [7:0] tx_data_o, // char sent
  input wire logic tx_valid_o, // record active
  input wire logic tx_ready_i, // host takes char
  input wire logic [2:0] alarm_o, // alarm code
  input wire logic [2:0] mode_o, // mode
  input wire wsc_pkg::wsc_pmode_t pmode_o // power mode
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // a bus cycle may override a command, so only clean commands are judged
  wire cmd = rx_valid_i && !wb_cyc_i;
  logic [5:0] cnt_q;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) cnt_q <= '0;
    else if (!tx_valid_o) cnt_q <= '0;
    else if (tx_ready_i) cnt_q <= cnt_q + 6'h01;
  end
  sequence s_poll;
    cmd && rx_data_i == wsc_pkg::CMD_POLL && !tx_valid_o;
  endsequence
  sequence s_start;
    tx_valid_o && tx_data_o == wsc_pkg::CH_SEMI;
  endsequence
  AST_POLL_START: assert property (s_poll |=> s_start) else $error("record start wrong");
  AST_ALARM_STEP: assert property (cmd && rx_data_i == wsc_pkg::CMD_ALARM |=>
    alarm_o == ($past(alarm_o) == 3'h4 ? 3'h0 : $past(alarm_o) + 3'h1)) else $error("alarm step wrong");
  AST_ALARM_RANGE: assert property (alarm_o <= 3'h4) else $error("alarm code out of range");
  AST_MODE_STEP: assert property (cmd && rx_data_i == wsc_pkg::CMD_MODE |=>
    mode_o == ($past(mode_o) == 3'h3 ? 3'h0 : $past(mode_o) + 3'h1)) else $error("mode step wrong");
  AST_PMODE_STEP: assert property (cmd && rx_data_i == wsc_pkg::CMD_PWR |=>
    pmode_o == ($past(pmode_o) == wsc_pkg::PM_TUNE ? 2'h0 : 2'($past(pmode_o) + 2'h1)))
    else $error("power mode step wrong");
  AST_UNKNOWN: assert property (cmd && !(rx_data_i inside {8'h41, 8'h4D, 8'h46, 8'h50}) |=>
    $stable({alarm_o, mode_o, pmode_o}) && !$rose(tx_valid_o)) else $error("unknown char acted on");
  AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("char changed while stalled");
  AST_REC_LEN: assert property ($fell(tx_valid_o) |-> cnt_q == 6'h2A) else $error("record length wrong");
endmodule
bind wsc_command_port wsc_checker wsc_checker_inst (.clock_i, .reset_i, .wb_cyc_i, .rx_data_i, .rx_valid_i,
  .tx_data_o, .tx_valid_o, .tx_ready_i, .alarm_o, .mode_o, .pmode_o);

// File: bench/wsc_host_model.sv
`timescale 1ns/1ps
module wsc_host_model (
  input wire logic clock_i, // system clock
  input wire logic reset_i, // async reset
  input wire logic [7:0] tx_data_i, // char from device
  input wire logic tx_valid_i, // char offered
  input wire logic slow_i, // stall every other cycle
  output logic tx_ready_o // char taken
);
  logic [7:0] got_q[$];
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      tx_ready_o <= 1'b0;
    end else begin
      if (tx_valid_i && tx_ready_o) got_q.push_back(tx_data_i);
      tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
    end
  end
endmodule

// File: bench/wsc_command_port_tb.sv
`timescale 1ns/1ps
module wsc_command_port_tb;
  logic clock_i = 0, reset_i = 1, cyc = 0, stb = 0, we = 0, rx_valid = 0, slow = 0;
  logic [3:0] adr = '0;
  logic [31:0] wdat = '0, rd, rng = 32'h14C5B, v;
  logic [7:0] rx_data = '0, c;
  logic [47:0] call;
  wsc_pkg::wsc_meas_t meas = '0, m;
  wire [31:0] wb_dat_o;
  wire [7:0] tx_data;
  wire [2:0] alarm, mode;
  wire wb_ack_o, tx_valid, tx_ready, tick;
  int tgap = 0, ticks = 0;
  wsc_pkg::wsc_pmode_t pmode;
  int error_cnt = 0, checks = 0, cyc_n = 0, m_al = 0, m_md = 0, m_pm = 1, drops = 0;
  wsc_command_port wsc_command_port_inst (.clock_i, .reset_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o, .rx_data_i(rx_data),
    .rx_valid_i(rx_valid), .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
    .baud_tick_o(tick), .meas_i(meas), .alarm_o(alarm), .mode_o(mode), .pmode_o(pmode));
  wsc_host_model wsc_host_model_inst (.clock_i, .reset_i, .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .slow_i(slow), .tx_ready_o(tx_ready));
  initial forever #10 clock_i = ~clock_i;
  // bit-rate enable spacing, measured from the second pulse on
  always @(posedge clock_i) begin
    if (!reset_i) begin
      if (tick === 1'b1) begin
        if (ticks > 0) chk(32'(tgap), 32'(wsc_pkg::CLK_HZ / wsc_pkg::BAUD_RATE));
        ticks++;
        tgap = 1;
      end else begin
        tgap++;
      end
    end
  end
  always @(posedge clock_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do @(posedge clock_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 0; stb <= 0;
  endtask
  task automatic send(input logic [7:0] ch);
    @(posedge clock_i);
    rx_valid <= 1; rx_data <= ch;
    @(posedge clock_i);
    rx_valid <= 0;
    case (ch)
      wsc_pkg::CMD_ALARM: m_al = (m_al + 1) % 5;
      wsc_pkg::CMD_MODE: m_md = (m_md + 1) % 4;
      wsc_pkg::CMD_PWR: m_pm = (m_pm + 1) % 3;
      wsc_pkg::CMD_POLL: if (tx_valid === 1'b1) drops++;
      default: drops++;
    endcase
    @(posedge clock_i);
    chk(32'({alarm, mode, pmode}), 32'((m_al << 5) | (m_md << 2) | m_pm));
  endtask
  // snapshot must survive meas changing and a second poll mid-record
  task automatic poll();
    logic [335:0] e;
    e = {8'h3B, meas.power, 8'h2C, meas.z, 8'h2C, meas.phase, 8'h2C, 8'(8'h30 + m_al), 8'h2C, call, 8'h2C,
      8'(8'h30 + meas.range), 8'h2C, (m_pm == 0 ? 8'h31 : 8'h30), 8'h2C, meas.dbm, 8'h2C, meas.swr};
    send(wsc_pkg::CMD_POLL);
    m = 194'({xs(), xs(), xs(), xs(), xs(), xs(), xs()});
    m.range = 2'(xs() % 3);
    meas <= m;
    send(wsc_pkg::CMD_POLL);
    while (wsc_host_model_inst.got_q.size() < 42) @(posedge clock_i);
    repeat (8) @(posedge clock_i);
    chk(wsc_host_model_inst.got_q.size(), 42);
    for (int i = 0; i < 42; i++) chk(wsc_host_model_inst.got_q[i], e[335 - 8 * i -: 8]);
    wsc_host_model_inst.got_q.delete();
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clock_i);
    reset_i <= 0;
    wb(0, wsc_pkg::REG_SETTINGS, 0);
    chk(rd, 32'h100);
    v = xs();
    call = {8'(8'h41 + v[7:0] % 26), 8'(8'h41 + v[15:8] % 26), 8'(8'h41 + v[23:16] % 26), 8'h31, 8'h20, 8'h20};
    wb(1, wsc_pkg::REG_CALL_HI, 32'(call[47:32]));
    wb(1, wsc_pkg::REG_CALL_LO, {call[31:16], 16'h0});
    for (int i = 0; i < 60; i++) begin
      v = xs();
      c = v[2] ? v[15:8] : (v[1] ? (v[0] ? 8'h41 : 8'h4D) : 8'h46);
      if (c == wsc_pkg::CMD_POLL) c = 8'h51;
      slow <= v[20];
      send(c);
    end
    poll();
    slow <= 1;
    poll();
    wb(0, wsc_pkg::REG_STATUS, 0);
    chk(32'(rd[15:8]), 32'(drops % 256));
    wb(1, wsc_pkg::REG_STATUS, 0);
    drops = 0;
    wb(0, wsc_pkg::REG_STATUS, 0);
    chk(32'(rd[15:8]), 32'h0);
    wb(0, 4'h2, 0);
    chk(rd, 32'h0);
    wb(1, wsc_pkg::REG_SETTINGS, 32'h034);
    m_al = 4; m_md = 3; m_pm = 0;
    send(wsc_pkg::CMD_ALARM);
    send(wsc_pkg::CMD_ALARM);
    slow <= 0;
    poll();
    end_of_test();
  end
endmodule
